// [core/fpsc_params.svh]
/*
 * constants of the flash program/status host controller.
 * assumes a 100 MHz clock and an asynchronous parallel NOR flash.
 */
`ifndef FPSC_PARAMS_SVH
`define FPSC_PARAMS_SVH

// ************************************************
// clock and flash bus timing
// ************************************************
`define FPSC_CLK_MHZ     100
`define FPSC_T_WE_NS     70
`define FPSC_T_WEH_NS    30
`define FPSC_T_ACC_NS    120
`define FPSC_T_OEH_NS    20
`define FPSC_WE_CYC      ((`FPSC_T_WE_NS * `FPSC_CLK_MHZ + 999) / 1000)
`define FPSC_WEH_CYC     ((`FPSC_T_WEH_NS * `FPSC_CLK_MHZ + 999) / 1000)
`define FPSC_OEH_CYC     ((`FPSC_T_OEH_NS * `FPSC_CLK_MHZ + 999) / 1000)
`define FPSC_SYNC_CYC    2
`define FPSC_RD_CYC      ((`FPSC_T_ACC_NS * `FPSC_CLK_MHZ + 999) / 1000 + `FPSC_SYNC_CYC)

// ************************************************
// flash widths and command codes
// ************************************************
`define FPSC_AW          24
`define FPSC_DW          16
`define FPSC_CMD_PROG    8'h40
`define FPSC_CMD_CLR     8'h50
`define FPSC_CMD_RDARR   8'hff

// ************************************************
// flash status bit positions
// ************************************************
`define FPSC_SR_READY    7
`define FPSC_SR_FAIL     4
`define FPSC_SR_VPE      3
`define FPSC_SR_PROT     1

// ************************************************
// register map, byte offsets
// ************************************************
`define FPSC_REG_CTRL    4'h0
`define FPSC_REG_ADDR    4'h4
`define FPSC_REG_DATA    4'h8
`define FPSC_REG_STAT    4'hc
`define FPSC_CTRL_GO     0
`define FPSC_CTRL_OP_LO  1
`define FPSC_CTRL_RP     8
`define FPSC_RP_RST      1'b1

`endif

// [core/fpsc_pkg.sv]
/*
 * types of the flash program/status host controller.
 * assumes fpsc_params.svh is on the include path.
 */
`include "fpsc_params.svh"

package fpsc_pkg;

    // ************************************************
    // operations and pins
    // ************************************************
    typedef enum logic [1:0] {
        FPSC_OP_PROG  = 2'h0,
        FPSC_OP_CLR   = 2'h1,
        FPSC_OP_RDARR = 2'h2,
        FPSC_OP_READ  = 2'h3
    } fpsc_op_t;

    typedef struct packed {
        logic                     ce_n;
        logic                     oe_n;
        logic                     we_n;
        logic                     rp_n;
        logic [`FPSC_AW-1:0]      addr;
        logic [`FPSC_DW-1:0]      dq;
        logic                     dq_oe;
    } fpsc_pins_t;

endpackage : fpsc_pkg

// [core/fpsc_host.sv]
/*
 * host controller that programs, polls, clears and reads a parallel NOR flash
 * through its pins, ordered by software over an Avalon-MM slave.
 * assumes the dq bus and completion pin come from outside the clock domain.
 */
// Function
// - program sends setup code 40h, then data, both to the same address.
// - after program, reads return status; poll ready bit until 1.
// - status refreshed by taking output enable high then low again.
// - after any error, software issues clear-status before retry.
// - full error check may follow each program or a series.
// - after the last program, write read-array code FFh.
// - reset/power-down held high throughout every program operation.
// - interrupted operations are reissued after normal operation returns.
// - read-array command needed before reading array after an operation.
`timescale 1ns/1ps

`include "fpsc_params.svh"

module fpsc_host (
    input  wire logic                i_ref_clk,
    input  wire logic                i_rst_n,
    input  wire logic [3:0]          i_avs_address,
    input  wire logic                i_avs_read,
    input  wire logic                i_avs_write,
    input  wire logic [31:0]         i_avs_writedata,
    output logic      [31:0]         o_avs_readdata,
    output logic                     o_avs_waitrequest,
    input  wire logic [`FPSC_DW-1:0] i_fl_dq,
    input  wire logic                i_fl_sts,
    output fpsc_pkg::fpsc_pins_t     o_fl
);
    import fpsc_pkg::*;

    // ************************************************
    // declarations
    // ************************************************
    typedef enum logic [2:0] {S_IDLE, S_WR, S_WREC, S_RD, S_RGAP} fpsc_state_t;

    localparam logic [7:0] WE_CYC  = 8'(`FPSC_WE_CYC);
    localparam logic [7:0] WEH_CYC = 8'(`FPSC_WEH_CYC);
    localparam logic [7:0] OEH_CYC = 8'(`FPSC_OEH_CYC);
    localparam logic [7:0] RD_CYC  = 8'(`FPSC_RD_CYC);

    fpsc_state_t         state_ff, nxt_state;
    fpsc_op_t            op_ff, nxt_op;
    fpsc_pins_t          pins_ff, nxt_pins;
    logic [7:0]          cnt_ff, nxt_cnt;
    logic                step_ff, nxt_step;
    logic [7:0]          sr_ff, nxt_sr;
    logic [`FPSC_DW-1:0] rdata_ff, nxt_rdata;
    logic                done_ff, nxt_done;
    logic [`FPSC_AW-1:0] addr_ff;
    logic [`FPSC_DW-1:0] data_ff;
    logic                rp_ff;
    logic                wait_ff;
    logic [31:0]         rd_ff;
    logic [`FPSC_DW-1:0] dq_s1_ff, dq_s2_ff;
    logic                sts_s1_ff, sts_s2_ff;

    // ************************************************
    // bus decode
    // ************************************************
    wire       acc      = i_avs_read | i_avs_write;
    wire       wr_take  = i_avs_write & ~wait_ff;
    wire       idle     = (state_ff == S_IDLE);
    wire       wr_ctrl  = wr_take & (i_avs_address == `FPSC_REG_CTRL);
    wire       wr_addr  = wr_take & (i_avs_address == `FPSC_REG_ADDR) & idle;
    wire       wr_data  = wr_take & (i_avs_address == `FPSC_REG_DATA) & idle;
    wire       rp_keep  = rp_ff & i_avs_writedata[`FPSC_CTRL_RP];
    wire       go       = wr_ctrl & idle & i_avs_writedata[`FPSC_CTRL_GO] & rp_keep;
    wire       err_any  = sr_ff[`FPSC_SR_FAIL] | sr_ff[`FPSC_SR_VPE] | sr_ff[`FPSC_SR_PROT];
    wire [1:0] op_field = i_avs_writedata[`FPSC_CTRL_OP_LO +: 2];
    wire [7:0] sample   = dq_s2_ff[7:0];
    wire       cnt_zero = (cnt_ff == 8'h00);
    wire [31:0] stat_word = {15'h0000, done_ff, sr_ff, 4'h0, err_any, sts_s2_ff, rp_ff, ~idle};
    wire [31:0] rd_mux =
        (i_avs_address == `FPSC_REG_CTRL) ? {23'h000000, rp_ff, 5'h00, op_ff, 1'b0} :
        (i_avs_address == `FPSC_REG_ADDR) ? {8'h00, addr_ff} :
        (i_avs_address == `FPSC_REG_DATA) ? {16'h0000, rdata_ff} :
        (i_avs_address == `FPSC_REG_STAT) ? stat_word : 32'h00000000;

    // ************************************************
    // sequencer
    // ************************************************
    always_comb begin
        nxt_state = state_ff;
        nxt_op    = op_ff;
        nxt_pins  = pins_ff;
        nxt_cnt   = cnt_zero ? cnt_ff : cnt_ff - 8'h01;
        nxt_step  = step_ff;
        nxt_sr    = sr_ff;
        nxt_rdata = rdata_ff;
        nxt_done  = done_ff;
        nxt_pins.rp_n = rp_ff;
        unique case (state_ff)
            S_IDLE: begin
                if (go) begin
                    nxt_op        = fpsc_op_t'(op_field);
                    nxt_done      = 1'b0;
                    nxt_step      = 1'b0;
                    nxt_pins.addr = addr_ff;
                    nxt_pins.ce_n = 1'b0;
                    if (fpsc_op_t'(op_field) == FPSC_OP_READ) begin
                        nxt_pins.oe_n  = 1'b0;
                        nxt_pins.dq_oe = 1'b0;
                        nxt_cnt        = RD_CYC;
                        nxt_state      = S_RD;
                    end else begin
                        nxt_pins.we_n  = 1'b0;
                        nxt_pins.dq_oe = 1'b1;
                        nxt_cnt        = WE_CYC;
                        nxt_state      = S_WR;
                        unique case (fpsc_op_t'(op_field))
                            FPSC_OP_CLR:   nxt_pins.dq = `FPSC_DW'(`FPSC_CMD_CLR);
                            FPSC_OP_RDARR: nxt_pins.dq = `FPSC_DW'(`FPSC_CMD_RDARR);
                            default:       nxt_pins.dq = `FPSC_DW'(`FPSC_CMD_PROG);
                        endcase
                    end
                end
            end
            S_WR: begin
                if (cnt_zero) begin
                    nxt_pins.we_n = 1'b1;
                    nxt_pins.ce_n = 1'b1;
                    nxt_cnt       = WEH_CYC;
                    nxt_state     = S_WREC;
                end
            end
            S_WREC: begin
                if (cnt_zero) begin
                    if (op_ff == FPSC_OP_PROG && !step_ff) begin
                        nxt_step      = 1'b1;
                        nxt_pins.dq   = data_ff;
                        nxt_pins.ce_n = 1'b0;
                        nxt_pins.we_n = 1'b0;
                        nxt_cnt       = WE_CYC;
                        nxt_state     = S_WR;
                    end else if (op_ff == FPSC_OP_PROG) begin
                        nxt_pins.dq_oe = 1'b0;
                        nxt_pins.ce_n  = 1'b0;
                        nxt_pins.oe_n  = 1'b0;
                        nxt_cnt        = RD_CYC;
                        nxt_state      = S_RD;
                    end else begin
                        nxt_pins.dq_oe = 1'b0;
                        if (op_ff == FPSC_OP_CLR) begin
                            nxt_sr = 8'h00;
                        end
                        nxt_done  = 1'b1;
                        nxt_state = S_IDLE;
                    end
                end
            end
            S_RD: begin
                if (cnt_zero) begin
                    nxt_pins.oe_n = 1'b1;
                    if (op_ff == FPSC_OP_PROG) begin
                        nxt_sr = sample;
                        if (sample[`FPSC_SR_READY]) begin
                            nxt_pins.ce_n = 1'b1;
                            nxt_done      = 1'b1;
                            nxt_state     = S_IDLE;
                        end else begin
                            nxt_cnt   = OEH_CYC;
                            nxt_state = S_RGAP;
                        end
                    end else begin
                        nxt_rdata     = dq_s2_ff;
                        nxt_pins.ce_n = 1'b1;
                        nxt_done      = 1'b1;
                        nxt_state     = S_IDLE;
                    end
                end
            end
            S_RGAP: begin
                if (cnt_zero) begin
                    nxt_pins.oe_n = 1'b0;
                    nxt_cnt       = RD_CYC;
                    nxt_state     = S_RD;
                end
            end
        endcase
    end

    // ************************************************
    // registers
    // ************************************************
    always_ff @(posedge i_ref_clk) begin
        dq_s1_ff  <= i_fl_dq;
        dq_s2_ff  <= dq_s1_ff;
        sts_s1_ff <= i_fl_sts;
        sts_s2_ff <= sts_s1_ff;
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            state_ff <= S_IDLE;
            op_ff    <= FPSC_OP_PROG;
            pins_ff  <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rp_n: 1'b1, default: '0};
            cnt_ff   <= 8'h00;
            step_ff  <= 1'b0;
            sr_ff    <= 8'h00;
            rdata_ff <= '0;
            done_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            op_ff    <= nxt_op;
            pins_ff  <= nxt_pins;
            cnt_ff   <= nxt_cnt;
            step_ff  <= nxt_step;
            sr_ff    <= rp_ff ? nxt_sr : 8'h00;
            rdata_ff <= nxt_rdata;
            done_ff  <= nxt_done;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            addr_ff <= '0;
            data_ff <= '0;
            rp_ff   <= `FPSC_RP_RST;
        end else begin
            if (wr_addr) begin
                addr_ff <= i_avs_writedata[`FPSC_AW-1:0];
            end
            if (wr_data) begin
                data_ff <= i_avs_writedata[`FPSC_DW-1:0];
            end
            if (wr_ctrl && idle) begin
                rp_ff <= i_avs_writedata[`FPSC_CTRL_RP];
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            wait_ff <= 1'b1;
            rd_ff   <= 32'h00000000;
        end else begin
            wait_ff <= ~(acc & wait_ff);
            if (i_avs_read && wait_ff) begin
                rd_ff <= rd_mux;
            end
        end
    end

    assign o_avs_waitrequest = wait_ff;
    assign o_avs_readdata    = rd_ff;
    assign o_fl              = pins_ff;

endmodule : fpsc_host

// [tb/fpsc_flash_model.sv]
/* behavioural flash device: command latch, status byte, one data word.
   assumes pins change just after i_clk edges; sts is a pulled-up open drain. */
`timescale 1ns/1ps
module fpsc_flash_model (
    input  wire logic           i_clk,
    input  fpsc_pkg::fpsc_pins_t i_pins,
    input  wire logic [2:0]     i_err,
    input  wire logic [5:0]     i_blen,
    output logic      [15:0]    o_dq,
    output logic                o_sts
);
    import fpsc_pkg::*;
    logic [7:0]  stat;
    logic [15:0] mem = 16'h0;
    logic [15:0] last = 16'h0;
    logic [4:1]  sr = 4'h0;
    logic        we_q = 1'b1;
    logic        setup = 1'b0;
    logic        st_mode = 1'b0;
    int          busy = 0;
    wire         rd_on = !i_pins.ce_n && !i_pins.oe_n;

    assign stat  = {busy == 0, 2'b0, sr[4], sr[3], 1'b0, sr[1], 1'b0};
    assign o_sts = (busy == 0);
    assign o_dq  = rd_on ? (st_mode ? {8'h0, stat} : mem) : ~last;

    always @(posedge i_clk) begin
        we_q <= i_pins.we_n;
        if (rd_on) last <= o_dq;
        if (busy != 0) busy <= busy - 1;
        if (!i_pins.rp_n) begin
            sr <= 4'h0;
            busy <= 0;
            setup <= 1'b0;
            st_mode <= 1'b0;
        end else if (!i_pins.we_n && we_q && !i_pins.ce_n && busy == 0) begin
            if (setup) begin
                setup <= 1'b0;
                busy <= i_blen;
                sr <= sr | {i_err[0], i_err[1], 1'b0, i_err[2]};
                if (i_err == 3'h0) mem <= i_pins.dq;
            end else begin
                case (i_pins.dq[7:0])
                    8'h40: begin
                        setup <= 1'b1;
                        st_mode <= 1'b1;
                    end
                    8'h50: sr <= 4'h0;
                    8'hff: st_mode <= 1'b0;
                    default: ;
                endcase
            end
        end
    end
endmodule : fpsc_flash_model

// [tb/fpsc_host_checker.sv]
/* checker of the flash pins and slave handshake of fpsc_host.
   bound to fpsc_host from the bench top. */
`timescale 1ns/1ps
module fpsc_host_checker (
    input  wire logic           i_ref_clk,
    input  wire logic           i_rst_n,
    input  wire logic           i_avs_read,
    input  wire logic           i_avs_write,
    input  wire logic           o_avs_waitrequest,
    input  fpsc_pkg::fpsc_pins_t o_fl
);
    import fpsc_pkg::*;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_wr_pulse;
        (!o_fl.we_n)[*8] ##1 o_fl.we_n[*4];
    endsequence
    sequence s_prog_pair;
        $fell(o_fl.we_n) && o_fl.dq == 16'h0040 ##12 $fell(o_fl.we_n);
    endsequence
    chk_ack_next: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("request not answered next cycle");
    chk_ack_one: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("waitrequest low too long");
    chk_wr_pulse: assert property ($fell(o_fl.we_n) |-> s_wr_pulse)
        else $error("write pulse timing wrong");
    chk_prog_addr: assert property (s_prog_pair |-> o_fl.addr == $past(o_fl.addr, 12))
        else $error("program data to other address");
    chk_poll_start: assert property (s_prog_pair |-> ##12 (!o_fl.oe_n && !o_fl.dq_oe))
        else $error("status read not started");
    chk_wr_drive: assert property (!o_fl.we_n |-> o_fl.dq_oe && !o_fl.ce_n && o_fl.oe_n)
        else $error("write without drive");
    chk_rd_release: assert property (!o_fl.oe_n |-> !o_fl.dq_oe && !o_fl.ce_n)
        else $error("read while driving");
    chk_oe_toggle: assert property ($rose(o_fl.oe_n) && !o_fl.ce_n |-> o_fl.oe_n[*3] ##1 !o_fl.oe_n)
        else $error("status refresh gap wrong");
    chk_rp_hold: assert property (!o_fl.ce_n |-> o_fl.rp_n)
        else $error("reset low during access");
endmodule : fpsc_host_checker

// [tb/flash_program_status_control_test.sv]
/* self-checking bench of fpsc_host with a flash model.
   assumes the package, header and checker are compiled first. */
`timescale 1ns/1ps
module flash_program_status_control_test;
    import fpsc_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  av_a = 4'h0;
    logic        av_rd = 1'b0;
    logic        av_wr = 1'b0;
    logic [31:0] av_wd = 32'h0;
    logic [31:0] av_q;
    logic        av_wait;
    logic [15:0] fl_dq;
    logic        fl_sts;
    fpsc_pins_t  fl;
    logic [2:0]  err = 3'h0;
    logic [5:0]  blen = 6'h5;
    int          n_fail = 0;
    int          n_tests = 0;
    int          exp_err = 0;
    int          exp_mem = 0;
    int          e;
    logic [31:0] q;
    logic [15:0] d;

    always #5 clk = ~clk;
    fpsc_host dut_u (.i_ref_clk(clk), .i_rst_n(rst_n), .i_avs_address(av_a), .i_avs_read(av_rd),
        .i_avs_write(av_wr), .i_avs_writedata(av_wd), .o_avs_readdata(av_q),
        .o_avs_waitrequest(av_wait), .i_fl_dq(fl_dq), .i_fl_sts(fl_sts), .o_fl(fl));
    fpsc_flash_model fl_u (.i_clk(clk), .i_pins(fl), .i_err(err), .i_blen(blen), .o_dq(fl_dq), .o_sts(fl_sts));

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask : chk

    task automatic av(input logic rd, input logic [3:0] a, input logic [31:0] wd);
        @(posedge clk);
        av_a <= a;
        av_rd <= rd;
        av_wr <= ~rd;
        av_wd <= wd;
        do @(posedge clk); while (av_wait !== 1'b0);
        q = av_q;
        av_rd <= 1'b0;
        av_wr <= 1'b0;
    endtask : av

    task automatic run(input int op);
        av(1'b0, 4'h0, 32'h101 | 32'(op << 1));
        if (op == 0) av(1'b0, 4'h8, 32'h5a5a);
        do av(1'b1, 4'hc, 32'h0); while (q[0] !== 1'b0);
    endtask : run

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (50000) @(posedge clk);
        n_fail++;
        end_of_test;
    end

    initial begin
        q = $urandom(48619);
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        av(1'b1, 4'hc, 32'h0);
        chk("stat_rst", q, 32'h6);
        av(1'b1, 4'h6, 32'h0);
        chk("unmapped", q, 32'h0);
        for (int i = 0; i < 8; i++) begin
            e = (i % 4 == 0) ? 0 : 1 << (i % 4 - 1);
            d = 16'($urandom) | 16'h8000;
            err <= 3'(e);
            blen <= 6'($urandom_range(40, 3));
            av(1'b0, 4'h4, $urandom);
            av(1'b0, 4'h8, {16'h0, d});
            run(0);
            exp_err |= (e & 1) * 16 | (e & 2) * 4 | (e & 4) / 2;
            if (e == 0) exp_mem = d;
            chk("status", q[15:8], 32'(8'h80 | exp_err));
            chk("err_sum", q[3], exp_err != 0);
            chk("done", q[16], 1'b1);
            if (i % 2 == 1) begin
                run(2);
                run(3);
                av(1'b1, 4'h8, 32'h0);
                chk("array", q[15:0], exp_mem);
            end
            if (i == 3) begin
                run(1);
                exp_err = 0;
                chk("cleared", q[15:8], 32'h0);
            end
        end
        av(1'b0, 4'h0, 32'h0);
        repeat (4) @(posedge clk);
        av(1'b1, 4'hc, 32'h0);
        chk("rp_low", q[15:0], 32'h4);
        av(1'b0, 4'h0, 32'h100);
        run(3);
        av(1'b1, 4'h8, 32'h0);
        chk("array_rp", q[15:0], exp_mem);
        err <= 3'h0;
        run(0);
        chk("status_rp", q[15:8], 32'h80);
        end_of_test;
    end
endmodule : flash_program_status_control_test

bind fpsc_host fpsc_host_checker chk_u (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest), .o_fl(o_fl));
